// *** design/mfd_flash_array.sv ***
// Flash word array with one registered read port and a program/erase port.
// Assumes commands and reads come from the access logic on the same clock.
`timescale 1ns/1ps
module mfd_flash_array (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rd_en,
  input wire logic [mfd_pkg::FL_ADDR_W-1:0] rd_addr,
  input wire mfd_pkg::mfd_flash_cmd_t cmd,
  output logic [mfd_pkg::PM_DATA_W-1:0] rd_data_q
);
  import mfd_pkg::*;

  // Array content survives reset, so it carries no reset
  logic [PM_DATA_W-1:0] mem_q [FL_WORDS];
  logic [PM_DATA_W-1:0] rd_data_d;

  ////////////////////////////////////////////////////////////////////////////
  // Read data next value
  always_comb begin
    rd_data_d = rd_data_q;
    if (rd_en) begin
      rd_data_d = mem_q[rd_addr];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-sector erase
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < FL_WORDS; i++) begin
      if (cmd.erase && mfd_sector_of(12'(i)) == cmd.sector) begin
        mem_q[i] <= FL_ERASED_WORD;
      end
    end
    if (cmd.prog) begin
      mem_q[cmd.addr] <= cmd.wdata;
    end
  end

endmodule : mfd_flash_array

// *** design/mfd_pkg.sv ***
// Package for the memory map decoder and flash access block.
// Holds address ranges, flash interface register layout, types and decode helpers.
// Assumes 14-bit program and data addresses from the processor core.
package mfd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and sizes
  localparam int ADDR_W = 14;
  localparam int PM_DATA_W = 24;
  localparam int DM_DATA_W = 16;
  localparam int FL_ADDR_W = 12;
  localparam int FL_WORDS = 4096;
  localparam int FL_SECT0_WORDS = 256;
  localparam int FL_SECT1_WORDS = 256;
  localparam int FL_SECT2_WORDS = 3584;
  localparam int NVB_COUNT = 4;
  localparam int NVB_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Program space ranges
  localparam logic [13:0] PM_VEC_LO = 14'h0000;
  localparam logic [13:0] PM_VEC_HI = 14'h002F;
  localparam logic [13:0] PM_URAM_LO = 14'h0030;
  localparam logic [13:0] PM_URAM_HI = 14'h01FF;
  localparam logic [13:0] PM_ROM_LO = 14'h0800;
  localparam logic [13:0] PM_ROM_HI = 14'h17FF;
  localparam logic [13:0] PM_FL0_LO = 14'h2000;
  localparam logic [13:0] PM_FL0_HI = 14'h20FF;
  localparam logic [13:0] PM_FL1_LO = 14'h2100;
  localparam logic [13:0] PM_FL1_HI = 14'h21FF;
  localparam logic [13:0] PM_FL2_LO = 14'h2200;
  localparam logic [13:0] PM_FL2_HI = 14'h2FFF;

  // Data space ranges
  localparam logic [13:0] DM_PERIPH_LO = 14'h2000;
  localparam logic [13:0] DM_PERIPH_HI = 14'h20FF;
  localparam logic [13:0] DM_RAM_LO = 14'h3800;
  localparam logic [13:0] DM_RAM_HI = 14'h39FF;
  localparam logic [13:0] DM_REGWIN_LO = 14'h3C00;
  localparam logic [13:0] DM_REGWIN_HI = 14'h3FFF;

  // Register addresses inside the upper register window
  localparam logic [13:0] FLASH_CONTROL_ADDR = 14'h3C10;
  localparam logic [13:0] FLASH_ADDRESS_ADDR = 14'h3C11;
  localparam logic [13:0] FLASH_DATA_LOW_ADDR = 14'h3C12;
  localparam logic [13:0] FLASH_DATA_HIGH_ADDR = 14'h3C13;
  localparam logic [13:0] WAIT_STATE_ADDR = 14'h3FFE;

  // Reset values, fast wait state and erased contents
  localparam logic [15:0] WAIT_STATE_RST = 16'hFFFF;
  localparam logic [15:0] WAIT_STATE_FAST = 16'h8000;
  localparam logic [13:0] BOOT_VECTOR = 14'h0800;
  localparam logic [15:0] FLASH_REG_RST = 16'h0000;
  localparam logic [23:0] FL_ERASED_WORD = 24'hFF_FFFF;
  localparam logic [7:0] NVB_ERASED = 8'h00;

  // Flash control register fields (command bits are self clearing)
  localparam int CTL_READ_BIT = 0;
  localparam int CTL_PROG_BIT = 1;
  localparam int CTL_ERASE_BIT = 2;
  localparam int CTL_NVB_WR_BIT = 3;
  localparam int CTL_NVB_RD_BIT = 4;
  localparam int CTL_NVB_ERASE_BIT = 5;
  localparam int CTL_SECT_LSB = 8;
  localparam int CTL_BUSY_BIT = 15;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {PM_VEC, PM_URAM, PM_ROM, PM_FLASH, PM_RSVD} mfd_pm_region_t;
  typedef enum logic [1:0] {DM_PERIPH, DM_RAM, DM_REGWIN, DM_RSVD} mfd_dm_region_t;
  typedef enum logic [1:0] {OWN_FETCH, OWN_OPER, OWN_CTRL} mfd_owner_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [13:0] addr;
    logic [23:0] wdata;
  } mfd_pm_req_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [13:0] addr;
    logic [15:0] wdata;
  } mfd_dm_req_t;

  typedef struct packed {
    logic prog;
    logic erase;
    logic [1:0] sector;
    logic [11:0] addr;
    logic [23:0] wdata;
  } mfd_flash_cmd_t;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic mfd_pm_region_t mfd_pm_decode(input logic [13:0] a);
    if (a <= PM_VEC_HI) return PM_VEC;
    if (a >= PM_URAM_LO && a <= PM_URAM_HI) return PM_URAM;
    if (a >= PM_ROM_LO && a <= PM_ROM_HI) return PM_ROM;
    if (a >= PM_FL0_LO && a <= PM_FL2_HI) return PM_FLASH;
    return PM_RSVD;
  endfunction : mfd_pm_decode

  function automatic mfd_dm_region_t mfd_dm_decode(input logic [13:0] a);
    if (a >= DM_PERIPH_LO && a <= DM_PERIPH_HI) return DM_PERIPH;
    if (a >= DM_RAM_LO && a <= DM_RAM_HI) return DM_RAM;
    if (a >= DM_REGWIN_LO) return DM_REGWIN;
    return DM_RSVD;
  endfunction : mfd_dm_decode

  // Sector number of a flash word offset
  function automatic logic [1:0] mfd_sector_of(input logic [11:0] off);
    if (off < 12'(FL_SECT0_WORDS)) return 2'd0;
    if (off < 12'(FL_SECT0_WORDS + FL_SECT1_WORDS)) return 2'd1;
    return 2'd2;
  endfunction : mfd_sector_of

endpackage : mfd_pkg

// *** design/mfd_top.sv ***
// Memory map decoder and flash access logic for the processor core.
// Assumes the core holds its requests stable while core_stall is high.
//
// How it works
// - Program and data spaces decode separately; program space holds RAM, ROM, flash.
// - Program space: vectors, user RAM, ROM at fixed ranges; gaps reserved.
// - Data space window 0x2000-0x20FF selects peripheral registers.
// - Data space: user RAM 0x3800-0x39FF, registers 0x3C00-0x3FFF; rest reserved.
// - Flash array of 4K words, 24 bits each, holds program code.
// - Three sectors: 256, 256 and 3584 words, each erasable alone.
// - Flash sectors appear at program addresses 0x2000, 0x2100, 0x2200.
// - Four 16-bit flash registers: control, address, data low, data high.
// - Fetch and operand flash reads share one bus; a collision costs a cycle.
// - Four nonvolatile 8-bit user bytes, reached apart from the array.
// - Erased user bytes read back as zero.
// - After reset the fetch vector points at ROM address 0x0800.
`timescale 1ns/1ps
module mfd_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic fetch_valid,
  input wire logic [mfd_pkg::ADDR_W-1:0] fetch_addr,
  input wire mfd_pkg::mfd_pm_req_t pm_req,
  input wire mfd_pkg::mfd_dm_req_t dm_req,
  output mfd_pkg::mfd_pm_region_t fetch_region,
  output mfd_pkg::mfd_pm_region_t pm_region,
  output mfd_pkg::mfd_dm_region_t dm_region,
  output logic core_stall,
  output logic [mfd_pkg::PM_DATA_W-1:0] flash_rdata,
  output logic flash_rvalid_q,
  output mfd_pkg::mfd_owner_t flash_rsrc_q,
  output logic [mfd_pkg::DM_DATA_W-1:0] dm_rdata_q,
  output logic dm_rvalid_q,
  output logic [mfd_pkg::ADDR_W-1:0] boot_vec_q
);
  import mfd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic fetch_fl;
  logic oper_fl;
  logic dm_rd;
  logic dm_wr;

  always_comb begin
    fetch_region = mfd_pm_decode(fetch_addr);
    pm_region = mfd_pm_decode(pm_req.addr);
    dm_region = mfd_dm_decode(dm_req.addr);
  end

  // flash sectors decoded from program space
  assign fetch_fl = fetch_valid && fetch_region == PM_FLASH;
  // flash writes from the bus do nothing
  assign oper_fl = pm_req.valid && !pm_req.we && pm_region == PM_FLASH;
  // reserved data addresses answer reads only
  assign dm_rd = dm_req.valid && !dm_req.we && dm_region inside {DM_REGWIN, DM_RSVD};
  assign dm_wr = dm_req.valid && dm_req.we && dm_region == DM_REGWIN;

  ////////////////////////////////////////////////////////////////////////////
  // Shared external bus arbitration
  logic hold_q;
  logic hold_d;
  logic ctrl_pend_q;
  logic ctrl_pend_d;
  logic ctrl_rd_req;
  logic bus_rd;
  logic [FL_ADDR_W-1:0] bus_addr;
  logic flash_rvalid_d;
  mfd_owner_t flash_rsrc_d;
  logic [15:0] addr_reg_q;

  // fetch first, operand on the inserted overhead cycle
  always_comb begin
    core_stall = fetch_fl && oper_fl && !hold_q;
    hold_d = core_stall;
    // Controller read goes out at once when neither core port wants the bus
    bus_rd = fetch_fl || oper_fl || ctrl_pend_q || ctrl_rd_req;
    flash_rsrc_d = OWN_CTRL;
    // Array word offset is the low twelve address bits
    bus_addr = addr_reg_q[FL_ADDR_W-1:0];
    if (oper_fl && (hold_q || !fetch_fl)) begin
      flash_rsrc_d = OWN_OPER;
      bus_addr = pm_req.addr[FL_ADDR_W-1:0];
    end else if (fetch_fl) begin
      flash_rsrc_d = OWN_FETCH;
      bus_addr = fetch_addr[FL_ADDR_W-1:0];
    end
    flash_rvalid_d = bus_rd;
    // Controller read waits for an idle bus slot
    ctrl_pend_d = (ctrl_pend_q || ctrl_rd_req) && (fetch_fl || oper_fl);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_q <= 1'b0;
      ctrl_pend_q <= 1'b0;
      flash_rvalid_q <= 1'b0;
      flash_rsrc_q <= OWN_FETCH;
    end else begin
      hold_q <= hold_d;
      ctrl_pend_q <= ctrl_pend_d;
      flash_rvalid_q <= flash_rvalid_d;
      flash_rsrc_q <= flash_rsrc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash interface registers and wait-state register
  logic [15:0] ctl_q;
  logic [15:0] ctl_d;
  logic [15:0] addr_reg_d;
  logic [15:0] dlo_q;
  logic [15:0] dlo_d;
  logic [15:0] dhi_q;
  logic [15:0] dhi_d;
  logic [15:0] wait_q;
  logic [15:0] wait_d;
  logic [7:0] nvb_q [NVB_COUNT];
  logic [7:0] nvb_d [NVB_COUNT];
  mfd_flash_cmd_t cmd;
  logic ctl_wr;
  logic ctrl_done;

  assign ctl_wr = dm_wr && dm_req.addr == FLASH_CONTROL_ADDR;
  assign ctrl_rd_req = ctl_wr && dm_req.wdata[CTL_READ_BIT];
  assign ctrl_done = flash_rvalid_q && flash_rsrc_q == OWN_CTRL;

  // register writes, array results and user byte commands
  always_comb begin
    ctl_d = ctl_q;
    addr_reg_d = addr_reg_q;
    dlo_d = dlo_q;
    dhi_d = dhi_q;
    wait_d = wait_q;
    cmd = '0;
    ctl_d[CTL_BUSY_BIT] = ctrl_pend_d || (bus_rd && flash_rsrc_d == OWN_CTRL);
    if (dm_wr && dm_req.addr == FLASH_ADDRESS_ADDR) begin
      addr_reg_d = dm_req.wdata;
    end
    if (dm_wr && dm_req.addr == FLASH_DATA_LOW_ADDR) begin
      dlo_d = dm_req.wdata;
    end
    if (dm_wr && dm_req.addr == FLASH_DATA_HIGH_ADDR) begin
      dhi_d = dm_req.wdata;
    end
    // wait-state register holds what software writes
    if (dm_wr && dm_req.addr == WAIT_STATE_ADDR) begin
      wait_d = dm_req.wdata;
    end
    if (ctl_wr) begin
      ctl_d[CTL_SECT_LSB +: 2] = dm_req.wdata[CTL_SECT_LSB +: 2];
      ctl_d[CTL_BUSY_BIT] = 1'b1;
      // sector erase; word program from data pair
      cmd.erase = dm_req.wdata[CTL_ERASE_BIT];
      cmd.prog = dm_req.wdata[CTL_PROG_BIT];
      cmd.sector = dm_req.wdata[CTL_SECT_LSB +: 2];
      cmd.addr = addr_reg_q[FL_ADDR_W-1:0];
      cmd.wdata = {dhi_q[7:0], dlo_q};
    end
    for (int i = 0; i < NVB_COUNT; i++) begin
      nvb_d[i] = nvb_q[i];
    end
    if (ctl_wr) begin
      // user byte write and read through the data low register
      if (dm_req.wdata[CTL_NVB_WR_BIT]) begin
        nvb_d[addr_reg_q[1:0]] = dlo_q[7:0];
      end
      if (dm_req.wdata[CTL_NVB_RD_BIT]) begin
        dlo_d = {8'h00, nvb_q[addr_reg_q[1:0]]};
      end
      // erased user bytes read as zero
      if (dm_req.wdata[CTL_NVB_ERASE_BIT]) begin
        for (int i = 0; i < NVB_COUNT; i++) begin
          nvb_d[i] = NVB_ERASED;
        end
      end
    end
    // Array result beats a same-cycle software write
    if (ctrl_done) begin
      dlo_d = flash_rdata[15:0];
      dhi_d = {8'h00, flash_rdata[23:16]};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctl_q <= FLASH_REG_RST;
      addr_reg_q <= FLASH_REG_RST;
      dlo_q <= FLASH_REG_RST;
      dhi_q <= FLASH_REG_RST;
      wait_q <= WAIT_STATE_RST;
    end else begin
      ctl_q <= ctl_d;
      addr_reg_q <= addr_reg_d;
      dlo_q <= dlo_d;
      dhi_q <= dhi_d;
      wait_q <= wait_d;
    end
  end

  // user bytes keep their content through reset
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NVB_COUNT; i++) begin
      nvb_q[i] <= nvb_d[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data bus read answer
  logic [15:0] dm_rdata_d;

  // flash registers readable by any code
  always_comb begin
    dm_rdata_d = '0;
    unique case (dm_req.addr)
      FLASH_CONTROL_ADDR: dm_rdata_d = ctl_q;
      FLASH_ADDRESS_ADDR: dm_rdata_d = addr_reg_q;
      FLASH_DATA_LOW_ADDR: dm_rdata_d = dlo_q;
      FLASH_DATA_HIGH_ADDR: dm_rdata_d = dhi_q;
      WAIT_STATE_ADDR: dm_rdata_d = wait_q;
      // reserved and unused addresses read zero
      default: dm_rdata_d = '0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dm_rdata_q <= '0;
      dm_rvalid_q <= 1'b0;
      // fetch starts in ROM after reset
      boot_vec_q <= BOOT_VECTOR;
    end else begin
      dm_rdata_q <= dm_rd ? dm_rdata_d : dm_rdata_q;
      dm_rvalid_q <= dm_rd;
      boot_vec_q <= BOOT_VECTOR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash array on the shared bus
  mfd_flash_array u_array (
    .core_clk(core_clk),
    .rst(rst),
    .rd_en(bus_rd),
    .rd_addr(bus_addr),
    .cmd(cmd),
    .rd_data_q(flash_rdata)
  );

endmodule : mfd_top

// *** verif/mfd_core_model.sv ***
// Core-side model: drives fetch, program and data requests.
// Assumes one clock; requests change 1 ns after the rising edge.
`timescale 1ns/1ps
module mfd_core_model (
  input wire logic core_clk,
  input wire logic core_stall,
  input wire logic [23:0] flash_rdata,
  input wire logic flash_rvalid_q,
  input wire mfd_pkg::mfd_owner_t flash_rsrc_q,
  input wire logic [15:0] dm_rdata_q,
  input wire logic dm_rvalid_q,
  output logic fetch_valid,
  output logic [13:0] fetch_addr,
  output mfd_pkg::mfd_pm_req_t pm_req,
  output mfd_pkg::mfd_dm_req_t dm_req
);
  import mfd_pkg::*;
  ////////////////////////////////////////
  // Idle buses at time zero
  initial begin
    fetch_valid = 1'b0;
    fetch_addr = 14'h3FFF;
    pm_req = '0;
    dm_req = '0;
  end
  // Addresses only, no request
  task automatic show(input logic [13:0] fa, input logic [13:0] pa, input logic [13:0] da);
    @(posedge core_clk);
    #1;
    fetch_addr = fa;
    pm_req.addr = pa;
    dm_req.addr = da;
  endtask : show
  // register reads and writes both go through this routine
  task automatic dm_op(input logic we, input logic [13:0] a, input logic [15:0] wd,
                       output logic [15:0] rd, output logic rv);
    @(posedge core_clk);
    #1 dm_req = '{valid: 1'b1, we: we, addr: a, wdata: wd};
    @(posedge core_clk);
    #1 dm_req = '{valid: 1'b0, we: 1'b0, addr: ~a, wdata: ~wd};
    @(negedge core_clk);
    rv = dm_rvalid_q;
    rd = dm_rdata_q;
  endtask : dm_op
  task automatic flash_rd(input logic fv, input logic [13:0] fa, input logic ov,
                          input logic [13:0] oa, output int s,
                          output logic [23:0] df, output logic [23:0] dof);
    logic st;
    logic done;
    s = 0;
    done = 1'b0;
    @(posedge core_clk);
    #1;
    fetch_valid = fv;
    fetch_addr = fa;
    pm_req = '{valid: ov, we: 1'b0, addr: oa, wdata: 24'h00_0000};
    repeat (4) begin
      @(negedge core_clk);
      if (flash_rvalid_q && flash_rsrc_q == OWN_FETCH) df = flash_rdata;
      if (flash_rvalid_q && flash_rsrc_q == OWN_OPER) dof = flash_rdata;
      st = core_stall;
      if (!done) s += int'(st);
      @(posedge core_clk);
      if (!done && !st) begin
        done = 1'b1;
        #1;
        fetch_valid = 1'b0;
        fetch_addr = ~fa;
        pm_req = '{valid: 1'b0, we: 1'b0, addr: ~oa, wdata: 24'hFF_FFFF};
      end
    end
  endtask : flash_rd
endmodule : mfd_core_model

// *** verif/mfd_top_properties.sv ***
// Checker for the memory map decoder and flash access block.
// Sees only top-level ports; one clock domain, active-high reset.
`timescale 1ns/1ps
module mfd_top_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic fetch_valid,
  input wire logic [13:0] fetch_addr,
  input wire mfd_pkg::mfd_pm_req_t pm_req,
  input wire mfd_pkg::mfd_dm_req_t dm_req,
  input wire mfd_pkg::mfd_pm_region_t fetch_region,
  input wire mfd_pkg::mfd_pm_region_t pm_region,
  input wire mfd_pkg::mfd_dm_region_t dm_region,
  input wire logic core_stall,
  input wire logic flash_rvalid_q,
  input wire mfd_pkg::mfd_owner_t flash_rsrc_q,
  input wire logic [15:0] dm_rdata_q,
  input wire logic dm_rvalid_q,
  input wire logic [13:0] boot_vec_q
);
  import mfd_pkg::*;
  logic fl_f;
  logic fl_o;
  ////////////////////////////////////////
  // Flash reads asked by fetch and operand
  assign fl_f = fetch_valid && fetch_region == PM_FLASH;
  assign fl_o = pm_req.valid && !pm_req.we && pm_region == PM_FLASH;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_stall_cause: assert property (core_stall |-> fl_f && fl_o)
    else $error("stall without a flash collision");
  chk_stall_raise: assert property (fl_f && fl_o && !$past(core_stall) |-> core_stall)
    else $error("flash collision without stall");
  chk_stall_order: assert property (core_stall |=>
    (!core_stall && flash_rvalid_q && flash_rsrc_q == OWN_FETCH)
    ##1 (flash_rvalid_q && flash_rsrc_q == OWN_OPER))
    else $error("collision not served fetch then operand");
  chk_fetch_serve: assert property (fl_f && !fl_o |=>
    flash_rvalid_q && flash_rsrc_q == OWN_FETCH) else $error("fetch read not answered");
  chk_oper_serve: assert property (fl_o && !fl_f |=>
    flash_rvalid_q && flash_rsrc_q == OWN_OPER) else $error("operand read not answered");
  chk_flash_map: assert property (
    (fetch_region == PM_FLASH) == (fetch_addr inside {[14'h2000:14'h2FFF]}))
    else $error("flash program range decode wrong");
  chk_pm_reserved: assert property (pm_req.addr inside {[14'h0200:14'h07FF],
    [14'h1800:14'h1FFF], [14'h3000:14'h3FFF]} |-> pm_region == PM_RSVD)
    else $error("program reserved hole decoded");
  chk_dm_map: assert property (
    (dm_region == DM_RAM) == (dm_req.addr inside {[14'h3800:14'h39FF]}) &&
    (dm_region == DM_PERIPH) == (dm_req.addr inside {[14'h2000:14'h20FF]}))
    else $error("data space decode wrong");
  chk_dm_answer: assert property (dm_req.valid && !dm_req.we |=>
    dm_rvalid_q == ($past(dm_region) inside {DM_REGWIN, DM_RSVD}))
    else $error("data read answer wrong");
  chk_rsvd_zero: assert property (dm_req.valid && !dm_req.we &&
    dm_region == DM_RSVD |=> dm_rdata_q == 16'h0000) else $error("reserved read not zero");
  chk_boot_vec: assert property (boot_vec_q == 14'h0800)
    else $error("boot vector wrong");
endmodule : mfd_top_chk
bind mfd_top mfd_top_chk u_chk (.core_clk, .rst, .fetch_valid, .fetch_addr, .pm_req,
  .dm_req, .fetch_region, .pm_region, .dm_region, .core_stall, .flash_rvalid_q,
  .flash_rsrc_q, .dm_rdata_q, .dm_rvalid_q, .boot_vec_q);

// *** verif/tb.sv ***
// Testbench for the memory map decoder and flash access block.
// Assumes the core model drives every request input of the block.
`timescale 1ns/1ps
module tb;
  import mfd_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic fetch_valid;
  logic [13:0] fetch_addr;
  mfd_pm_req_t pm_req;
  mfd_dm_req_t dm_req;
  mfd_pm_region_t fetch_region;
  mfd_pm_region_t pm_region;
  mfd_dm_region_t dm_region;
  logic core_stall;
  logic [23:0] flash_rdata;
  logic flash_rvalid_q;
  mfd_owner_t flash_rsrc_q;
  logic [15:0] dm_rdata_q;
  logic dm_rvalid_q;
  logic [13:0] boot_vec_q;
  int miscompares = 0;
  int checked = 0;
  ////////////////////////////////////////
  // Clock at 250 MHz
  always #2 core_clk = ~core_clk;
  mfd_top dut (.core_clk, .rst, .fetch_valid, .fetch_addr, .pm_req, .dm_req, .fetch_region,
    .pm_region, .dm_region, .core_stall, .flash_rdata, .flash_rvalid_q, .flash_rsrc_q,
    .dm_rdata_q, .dm_rvalid_q, .boot_vec_q);
  mfd_core_model u_core (.core_clk, .core_stall, .flash_rdata, .flash_rvalid_q,
    .flash_rsrc_q, .dm_rdata_q, .dm_rvalid_q, .fetch_valid, .fetch_addr, .pm_req, .dm_req);
  // Test word for a flash offset
  function automatic logic [23:0] pat(input logic [11:0] o);
    return {o[7:0] ^ 8'hA5, o, 4'h3};
  endfunction : pat
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    logic [15:0] r;
    logic v;
    u_core.dm_op(1'b1, a, d, r, v);
  endtask : wr
  task automatic rdc(input string nm, input logic [13:0] a, input logic [15:0] e);
    logic [15:0] r;
    logic v;
    u_core.dm_op(1'b0, a, 16'h0000, r, v);
    chk(nm, {8'h01, e}, {7'h00, v, r});
  endtask : rdc
  task automatic fchk(input logic [11:0] o, input logic [23:0] e);
    int s;
    logic [23:0] df;
    logic [23:0] dof;
    u_core.flash_rd(1'b1, 14'h2000 + 14'(o), 1'b0, 14'h0000, s, df, dof);
    chk("fetch word", e, df);
    chk("stall count", 24'h00_0000, 24'(s));
  endtask : fchk
  ////////////////////////////////////////
  // Reset values and wait-state setup
  task automatic t_reset;
    chk("boot vector", 24'h00_0800, {10'h000, boot_vec_q});
    rdc("wait state", WAIT_STATE_ADDR, 16'hFFFF);
    rdc("control reg", FLASH_CONTROL_ADDR, 16'h0000);
    wr(WAIT_STATE_ADDR, 16'h8000);
    rdc("wait state", WAIT_STATE_ADDR, 16'h8000);
  endtask : t_reset
  // Region boundaries in both spaces
  task automatic t_decode;
    logic [13:0] a [21] = '{14'h0000, 14'h002F, 14'h0030, 14'h01FF, 14'h0200, 14'h07FF,
      14'h0800, 14'h17FF, 14'h1800, 14'h2000, 14'h20FF, 14'h2100, 14'h2FFF, 14'h3000,
      14'h37FF, 14'h3800, 14'h39FF, 14'h3A00, 14'h3BFF, 14'h3C00, 14'h3FFF};
    mfd_pm_region_t p [21] = '{PM_VEC, PM_VEC, PM_URAM, PM_URAM, PM_RSVD, PM_RSVD, PM_ROM,
      PM_ROM, PM_RSVD, PM_FLASH, PM_FLASH, PM_FLASH, PM_FLASH, PM_RSVD, PM_RSVD, PM_RSVD,
      PM_RSVD, PM_RSVD, PM_RSVD, PM_RSVD, PM_RSVD};
    mfd_dm_region_t d [21] = '{DM_RSVD, DM_RSVD, DM_RSVD, DM_RSVD, DM_RSVD, DM_RSVD,
      DM_RSVD, DM_RSVD, DM_RSVD, DM_PERIPH, DM_PERIPH, DM_RSVD, DM_RSVD, DM_RSVD, DM_RSVD,
      DM_RAM, DM_RAM, DM_RSVD, DM_RSVD, DM_REGWIN, DM_REGWIN};
    for (int i = 0; i < 21; i++) begin
      u_core.show(a[i], a[i], a[i]);
      @(negedge core_clk);
      chk("fetch_region", 24'(p[i]), 24'(fetch_region));
      chk("pm_region", 24'(p[i]), 24'(pm_region));
      chk("dm_region", 24'(d[i]), 24'(dm_region));
    end
  endtask : t_decode
  // Register readback and reserved places
  task automatic t_regs;
    wr(FLASH_ADDRESS_ADDR, 16'h0ABC);
    rdc("address reg", FLASH_ADDRESS_ADDR, 16'h0ABC);
    wr(14'h3A00, 16'h1234);
    rdc("reserved ram", 14'h3A00, 16'h0000);
    wr(14'h3C20, 16'h5678);
    rdc("unmapped reg", 14'h3C20, 16'h0000);
  endtask : t_regs
  // Program sector edges, fetch and read back
  task automatic t_prog;
    logic [11:0] o [5] = '{12'h005, 12'h0FF, 12'h100, 12'h200, 12'hFFF};
    logic [23:0] w;
    int s;
    logic [23:0] df;
    logic [23:0] dof;
    foreach (o[i]) begin
      wr(FLASH_ADDRESS_ADDR, {4'h0, o[i]});
      wr(FLASH_DATA_LOW_ADDR, 16'(pat(o[i])));
      wr(FLASH_DATA_HIGH_ADDR, 16'(pat(o[i]) >> 16));
      wr(FLASH_CONTROL_ADDR, 16'h0002);
    end
    foreach (o[i]) fchk(o[i], pat(o[i]));
    w = pat(12'h200);
    wr(FLASH_ADDRESS_ADDR, 16'h0200);
    wr(FLASH_CONTROL_ADDR, 16'h0001);
    repeat (3) @(posedge core_clk);
    rdc("data low", FLASH_DATA_LOW_ADDR, w[15:0]);
    rdc("data high", FLASH_DATA_HIGH_ADDR, {8'h00, w[23:16]});
    u_core.flash_rd(1'b1, 14'h2005, 1'b1, 14'h2100, s, df, dof);
    chk("stall count", 24'h00_0001, 24'(s));
    chk("fetch word", pat(12'h005), df);
    chk("operand word", pat(12'h100), dof);
    u_core.flash_rd(1'b0, 14'h0000, 1'b1, 14'h2FFF, s, df, dof);
    chk("operand word", pat(12'hFFF), dof);
    wr(FLASH_CONTROL_ADDR, 16'h0104);
    fchk(12'h100, FL_ERASED_WORD);
    fchk(12'h1FF, FL_ERASED_WORD);
    fchk(12'h0FF, pat(12'h0FF));
    fchk(12'h200, pat(12'h200));
  endtask : t_prog
  // Nonvolatile user bytes: erase, write, read
  task automatic t_nvb;
    logic [15:0] r;
    logic v;
    wr(FLASH_CONTROL_ADDR, 16'h0020);
    for (int k = 0; k < 8; k++) begin
      wr(FLASH_ADDRESS_ADDR, 16'(k % 4));
      wr(FLASH_CONTROL_ADDR, 16'h0010);
      u_core.dm_op(1'b0, FLASH_DATA_LOW_ADDR, 16'h0000, r, v);
      if (k < 4) chk("erased byte", 24'h00_0000, {16'h0000, r[7:0]});
      else chk("user byte", {16'h0000, 8'hA0 + 8'(k)}, {16'h0000, r[7:0]});
      if (k < 4) wr(FLASH_DATA_LOW_ADDR, 16'h00A4 + 16'(k));
      if (k < 4) wr(FLASH_CONTROL_ADDR, 16'h0008);
    end
  endtask : t_nvb
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    #1 rst = 1'b0;
    t_reset();
    t_decode();
    t_regs();
    t_prog();
    t_nvb();
    end_of_test();
  end
  // Watchdog
  initial begin
    #40000;
    miscompares++;
    end_of_test();
  end
endmodule : tb
